// >>> bench/ext_micro.sv
// Model of the external microprocessor on the port pins.
// Assumes mclk paces it; a data line that nobody drives floats.
`timescale 1ns/1ps

module ext_micro (
  input  wire logic       mclk,
  input  wire logic [7:0] dataPinOut,
  input  wire logic [7:0] dataPinOen,
  output logic      [7:0] dataPinIn,
  output logic      [2:0] ctrlPinIn
);
  logic [7:0] hostData;
  logic       hostDrive;
  logic [7:0] lastLevel;

  initial begin
    hostData = 8'h00;
    hostDrive = 1'b0;
    lastLevel = 8'h00;
    ctrlPinIn = 3'h7;
  end

  // A floating line shows the inverse of its last level.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dataPinIn[i] = !dataPinOen[i] ? dataPinOut[i] : hostDrive ? hostData[i] : ~lastLevel[i];
    end
  end

  always @(posedge mclk) begin
    lastLevel <= dataPinIn;
  end

  task automatic access(input logic isWr, input logic sel, input logic [7:0] d, input int len,
                        output logic [7:0] q);
    @(posedge mclk);
    hostData <= d;
    hostDrive <= isWr;
    ctrlPinIn <= {~sel, ~isWr, isWr};
    repeat (len) @(posedge mclk);
    q = dataPinIn;
    ctrlPinIn <= 3'h7;
    @(posedge mclk);
    hostDrive <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask
endmodule

// >>> bench/parallel_slave_port_props.sv
// Checker for the parallel slave port: bus timing, pin steering and interrupt masking.
// Assumes it is bound to parallel_slave_port and sees only that module's ports.
`timescale 1ns/1ps

module parallel_slave_port_props (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0]  dataPinOut,
  input wire logic [7:0]  dataPinOen,
  input wire logic [2:0]  ctrlPinIn,
  input wire logic [2:0]  ctrlPinOen,
  input wire logic        irq
);
  logic       acc;
  logic       rdAct;
  logic       wrPh_q;
  logic [7:0] wrIdx_q;
  logic       portSel_q;
  logic       irqEn_q;
  logic [3:0] idleCnt_q;
  logic [2:0] rdCnt_q;
  logic [2:0] relCnt_q;

  assign acc = hsel && hready && htrans[1];
  assign rdAct = portSel_q && !ctrlPinIn[0] && !ctrlPinIn[2];

  // Shadows of port mode and interrupt enable, updated in the write data phase.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrPh_q <= 1'b0;
      wrIdx_q <= 8'h00;
      portSel_q <= 1'b0;
      irqEn_q <= 1'b0;
    end else begin
      wrPh_q <= acc && hwrite;
      wrIdx_q <= haddr[9:2];
      if (wrPh_q && wrIdx_q == psp_pkg::IDX_STATUS_DIR) begin
        portSel_q <= hwdata[psp_pkg::BIT_PORT_SELECT];
      end
      if (wrPh_q && wrIdx_q == psp_pkg::IDX_IRQ_ENABLES) begin
        irqEn_q <= hwdata[psp_pkg::BIT_PORT_IRQ];
      end
    end
  end

  // Saturating counts of quiet strobes, of a selected read and of its absence.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      idleCnt_q <= 4'h0;
      rdCnt_q <= 3'h0;
      relCnt_q <= 3'h0;
    end else begin
      idleCnt_q <= (ctrlPinIn != 3'h7) ? 4'h0 : idleCnt_q + 4'((idleCnt_q != 4'hf));
      rdCnt_q <= !rdAct ? 3'h0 : rdCnt_q + 3'((rdCnt_q != 3'h7));
      relCnt_q <= (rdAct || !portSel_q) ? 3'h0 : relCnt_q + 3'((relCnt_q != 3'h7));
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence rdReq;
    acc && !hwrite;
  endsequence
  sequence wrReq(idx);
    acc && hwrite && haddr[9:2] == idx;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_read_wait: assert property (rdReq |=> !hreadyout ##1 (hreadyout && hrdata[31:8] == 24'h0))
    else $error("read data phase timing wrong");
  a_write_nowait: assert property (acc && hwrite |=> hreadyout)
    else $error("write data phase waited");
  a_ctrl_dir: assert property (
    wrReq(psp_pkg::IDX_STATUS_DIR) ##1 1'b1 |-> ##2 ctrlPinOen == $past(hwdata[2:0], 2))
    else $error("control pin direction not taken");
  a_out_latch: assert property (
    wrReq(psp_pkg::IDX_DATA_LATCH) ##1 1'b1 |-> ##2 dataPinOut == $past(hwdata[7:0], 2))
    else $error("outbound latch not loaded");
  a_pin_release: assert property (relCnt_q == 3'h7 |-> dataPinOen == 8'hff)
    else $error("data pins driven without a read");
  a_pin_drive: assert property (rdCnt_q == 3'h7 |-> dataPinOen == 8'h00)
    else $error("data pins not driven in a read");
  a_irq_mask: assert property (irq |-> irqEn_q || $past(irqEn_q))
    else $error("irq while disabled");
  a_irq_clear: assert property (
    wrReq(psp_pkg::IDX_IRQ_CLEAR) ##1 (hwdata[7] && idleCnt_q == 4'hf) |-> ##2 !irq)
    else $error("irq not cleared");
endmodule

bind parallel_slave_port parallel_slave_port_props u_props (
  .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .dataPinOut(dataPinOut), .dataPinOen(dataPinOen), .ctrlPinIn(ctrlPinIn),
  .ctrlPinOen(ctrlPinOen), .irq(irq));

// >>> bench/tb.sv
// Self-checking bench: registers over AHB-Lite, external transfers, interrupt.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps

module tb;
  logic        mclk;
  logic        resetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  dataPinIn;
  logic [7:0]  dataPinOut;
  logic [7:0]  dataPinOen;
  logic [2:0]  ctrlPinIn;
  logic [2:0]  ctrlPinOen;
  logic [2:0]  ctrlPinOut;
  logic        irq;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [7:0]  got;
  int          n_fail;
  int          checks;
  int          seed;

  parallel_slave_port #(.SYNC_STAGES(2)) u_parallel_slave_port (
    .mclk(mclk), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dataPinIn(dataPinIn),
    .dataPinOut(dataPinOut), .dataPinOen(dataPinOen), .ctrlPinIn(ctrlPinIn),
    .ctrlPinOut(ctrlPinOut), .ctrlPinOen(ctrlPinOen), .irq(irq));
  ext_micro u_ext_micro (.mclk(mclk), .dataPinOut(dataPinOut), .dataPinOen(dataPinOen),
    .dataPinIn(dataPinIn), .ctrlPinIn(ctrlPinIn));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [31:0] status(input logic inbound_full_flag, outbound_full_flag, ov, mode);
    return {24'h0, inbound_full_flag, outbound_full_flag, ov, mode, 4'h7};
  endfunction

  task automatic summarize();
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chkIrq(input logic exp);
    @(posedge mclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask

  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      summarize();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] q);
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= psp_pkg::HTRANS_NONSEQ;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    logic [31:0] q;
    ahb(1'b1, idx, v, q);
  endtask

  task automatic rdChk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, idx, 32'h0, q);
    chk(what, exp, q);
  endtask

  task automatic ext(input logic isWr, input logic sel, input logic [7:0] d);
    u_ext_micro.access(isWr, sel, d, 6 + ($random(seed) & 7), got);
  endtask

  initial begin
    seed = 36;
    n_fail = 0;
    checks = 0;
    resetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rdChk("status", psp_pkg::IDX_STATUS_DIR, status(0, 0, 0, 0));
    rdChk("flags", psp_pkg::IDX_IRQ_FLAGS, 32'h0);
    rdChk("enables", psp_pkg::IDX_IRQ_ENABLES, 32'h0);
    rdChk("ctrl pins", psp_pkg::IDX_CTRL_PINS, 32'h7);
    rdChk("unmapped", 8'h40, 32'h0);
    ext(1'b1, 1'b1, 8'h5a);
    rdChk("flags", psp_pkg::IDX_IRQ_FLAGS, 32'h0);
    wr(psp_pkg::IDX_STATUS_DIR, status(0, 0, 0, 1));
    wr(psp_pkg::IDX_DATA_DIR, 32'h0);
    wr(psp_pkg::IDX_IRQ_ENABLES, 32'h80);
    ext(1'b1, 1'b0, 8'ha5);
    rdChk("status", psp_pkg::IDX_STATUS_DIR, status(0, 0, 0, 1));
    chkIrq(1'b0);
    chk("pin enable", 32'hff, {24'h0, dataPinOen});
    for (int i = 0; i < 6; i++) begin
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      ext(1'b1, 1'b1, b0);
      rdChk("status", psp_pkg::IDX_STATUS_DIR, status(1, 0, 0, 1));
      chkIrq(1'b1);
      wr(psp_pkg::IDX_IRQ_CLEAR, 32'h80);
      chkIrq(1'b0);
      rdChk("in latch", psp_pkg::IDX_DATA_LATCH, {24'h0, b0});
      wr(psp_pkg::IDX_DATA_LATCH, {24'h0, b1});
      rdChk("status", psp_pkg::IDX_STATUS_DIR, status(0, 1, 0, 1));
      ext(1'b0, 1'b1, 8'h00);
      chk("out byte", {24'h0, b1}, {24'h0, got});
      rdChk("status", psp_pkg::IDX_STATUS_DIR, status(0, 0, 0, 1));
      wr(psp_pkg::IDX_IRQ_ENABLES, i[0] ? 32'h0 : 32'h80);
      chkIrq(!i[0]);
      wr(psp_pkg::IDX_IRQ_ENABLES, 32'h80);
      wr(psp_pkg::IDX_IRQ_CLEAR, 32'h80);
    end
    b0 = 8'($random(seed));
    ext(1'b1, 1'b1, b0);
    ext(1'b1, 1'b1, ~b0);
    rdChk("status", psp_pkg::IDX_STATUS_DIR, status(1, 0, 1, 1));
    rdChk("in latch", psp_pkg::IDX_DATA_LATCH, {24'h0, b0});
    wr(psp_pkg::IDX_DATA_LATCH, 32'h3c);
    wr(psp_pkg::IDX_STATUS_DIR, status(0, 0, 1, 0));
    rdChk("status", psp_pkg::IDX_STATUS_DIR, status(0, 0, 1, 0));
    wr(psp_pkg::IDX_STATUS_DIR, status(0, 0, 0, 0));
    rdChk("status", psp_pkg::IDX_STATUS_DIR, status(0, 0, 0, 0));
    chk("pin enable", 32'h0, {24'h0, dataPinOen});
    b1 = 8'($random(seed));
    wr(psp_pkg::IDX_CTRL_PINS, {24'h0, b1});
    wr(psp_pkg::IDX_STATUS_DIR, {29'h0, b1[5:3]});
    rdChk("status", psp_pkg::IDX_STATUS_DIR, {29'h0, b1[5:3]});
    chk("ctrl out", {29'h0, b1[2:0]}, {29'h0, ctrlPinOut});
    chk("ctrl dir", {29'h0, b1[5:3]}, {29'h0, ctrlPinOen});
    summarize();
  end
endmodule

// >>> rtl/parallel_slave_port.sv
// Eight-bit parallel slave port with its AHB-Lite register file and interrupt.
// Assumes the external strobes, chip select and data pins are asynchronous to
// mclk; a pad ring resolves each two-way pin from its output and enable.
// Contract
// RULE_01: Port-select bit set turns data pins into an 8-bit external slave port.
// RULE_02: In port mode pins 0, 1, 2 are active-low read, write, chip select.
// RULE_03: Software enabling port mode also sets the three control pin direction bits.
// RULE_04: Two latches share one address: CPU writes outbound, reads inbound.
// RULE_05: In port mode data direction register is ignored; strobes steer data pins.
// RULE_06: Inbound-full at bit 7 sets on external write, clears on CPU read.
// RULE_07: Outbound-full at bit 6 sets on CPU write, clears on external read.
// RULE_08: External write while inbound full sets overrun bit 5, keeps first byte.
// RULE_09: Outside port mode both full flags held zero; overrun stays until cleared.
// RULE_10: Port interrupt flag bit 7 latches per completed external access; software clears.
// RULE_11: Port interrupt forwarded only while enable bit 7 is set.
// RULE_12: External accesses are asynchronous, controlled only by the strobes.
// RULE_13: External read occurs while read strobe and chip select are low.
// RULE_14: External write occurs while write strobe and chip select are low.
// RULE_15: Chip select high means deselected; strobes ignored.
// RULE_16: Data pins released unless selected read; inbound byte caught at write end.
`timescale 1ns/1ps

module parallel_slave_port #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Data pins.
  input  wire logic [7:0]  dataPinIn,
  output logic      [7:0]  dataPinOut,
  output logic      [7:0]  dataPinOen,
  // Control pins: bit 0 read strobe, bit 1 write strobe, bit 2 chip select.
  input  wire logic [2:0]  ctrlPinIn,
  output logic      [2:0]  ctrlPinOut,
  output logic      [2:0]  ctrlPinOen,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic       rstN;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  // ----------------------------------------------------------------------
  // Pin synchronisers; only the last stage is read.
  // ----------------------------------------------------------------------
  logic [10:0] pinSync_q [SYNC_STAGES];
  logic [7:0]  dataS;
  logic [2:0]  ctrlS;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        pinSync_q[i] <= 11'h7ff;
      end
    end else begin
      pinSync_q[0] <= {ctrlPinIn, dataPinIn};  // [RULE_12]
      for (int i = 1; i < SYNC_STAGES; i++) begin
        pinSync_q[i] <= pinSync_q[i-1];
      end
    end
  end

  assign dataS = pinSync_q[SYNC_STAGES-1][7:0];
  assign ctrlS = pinSync_q[SYNC_STAGES-1][10:8];

  // ----------------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------------
  logic       portSelect_q;
  logic [2:0] ctrlDir_q;
  logic [2:0] ctrlLatch_q;
  logic [7:0] dataDir_q;
  logic [7:0] outLatch_q;
  logic [7:0] inLatch_q;
  logic       inFull_q;
  logic       outFull_q;
  logic       overrun_q;
  logic       irqFlag_q;
  logic       irqEnable_q;

  // ----------------------------------------------------------------------
  // External strobe decode.
  // ----------------------------------------------------------------------
  logic extRead;
  logic extWrite;
  logic extRead_q;
  logic extWrite_q;
  logic [7:0] wrHold_q;
  logic readDone;
  logic writeDone;

  // A strobe only counts while selected and in port mode.
  assign extRead  = portSelect_q && !ctrlS[psp_pkg::PIN_READ]     // [RULE_02] [RULE_13]
                    && !ctrlS[psp_pkg::PIN_SELECT];               // [RULE_15]
  assign extWrite = portSelect_q && !ctrlS[psp_pkg::PIN_WRITE]    // [RULE_02] [RULE_14]
                    && !ctrlS[psp_pkg::PIN_SELECT];               // [RULE_15]

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      extRead_q  <= 1'b0;
      extWrite_q <= 1'b0;
      wrHold_q   <= psp_pkg::RST_BYTE;
    end else begin
      extRead_q  <= extRead;
      extWrite_q <= extWrite;
      // Hold the byte seen during the write so its end captures settled data.
      if (extWrite) begin
        wrHold_q <= dataS;
      end
    end
  end

  assign readDone  = extRead_q && !extRead;
  assign writeDone = extWrite_q && !extWrite;   // [RULE_16]

  // ----------------------------------------------------------------------
  // AHB-Lite slave. Writes take no wait; reads take one wait state.
  // ----------------------------------------------------------------------
  logic       accept;
  logic       wrPend_q;
  logic       rdPend_q;
  logic [7:0] idx_q;
  logic       wrPhase;
  logic       rdSample;
  logic [7:0] wByte;
  logic [7:0] rdByte;

  function automatic logic isIdx(input logic [7:0] idx, input logic [7:0] want);
    return idx == want;
  endfunction

  assign accept = hsel && hready
                  && (htrans == psp_pkg::HTRANS_NONSEQ || htrans == psp_pkg::HTRANS_SEQ);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      idx_q    <= 8'h00;
    end else begin
      if (hready || rdPend_q) begin
        wrPend_q <= accept && hwrite;
        rdPend_q <= accept && !hwrite;
      end
      if (accept) begin
        idx_q <= (haddr[31:10] == 22'h0) ? haddr[9:2] : 8'hff;
      end
    end
  end

  assign wrPhase   = wrPend_q;
  assign rdSample  = rdPend_q && !hreadyout;
  assign wByte     = hwdata[7:0];
  assign hresp     = 1'b0;

  logic readWait_q;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      readWait_q <= 1'b0;
    end else begin
      readWait_q <= accept && !hwrite && !readWait_q;
    end
  end

  assign hreadyout = !readWait_q;

  always_comb begin
    rdByte = 8'h00;
    case (idx_q)
      psp_pkg::IDX_DATA_LATCH:  rdByte = portSelect_q ? inLatch_q : dataS;  // [RULE_04]
      psp_pkg::IDX_CTRL_PINS:   rdByte = {5'h00, ctrlS};
      psp_pkg::IDX_IRQ_FLAGS:   rdByte = {irqFlag_q, 7'h00};
      psp_pkg::IDX_DATA_DIR:    rdByte = dataDir_q;
      psp_pkg::IDX_STATUS_DIR:  rdByte = {inFull_q, outFull_q, overrun_q, portSelect_q,
                                          1'b0, ctrlDir_q};
      psp_pkg::IDX_IRQ_ENABLES: rdByte = {irqEnable_q, 7'h00};
      default:                  rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      hrdata <= 32'h0000_0000;
    end else if (rdSample) begin
      hrdata <= {24'h00_0000, rdByte};
    end
  end

  // ----------------------------------------------------------------------
  // Software-written registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      portSelect_q <= 1'b0;
      ctrlDir_q    <= psp_pkg::RST_CTRL_DIR;
      ctrlLatch_q  <= 3'h0;
      dataDir_q    <= psp_pkg::RST_DATA_DIR;
      outLatch_q   <= psp_pkg::RST_BYTE;
      irqEnable_q  <= 1'b0;
    end else if (wrPhase) begin
      if (isIdx(idx_q, psp_pkg::IDX_STATUS_DIR)) begin
        portSelect_q <= wByte[psp_pkg::BIT_PORT_SELECT];  // [RULE_01]
        ctrlDir_q    <= wByte[2:0];                       // [RULE_03]
      end
      if (isIdx(idx_q, psp_pkg::IDX_CTRL_PINS)) begin
        ctrlLatch_q <= wByte[2:0];
      end
      if (isIdx(idx_q, psp_pkg::IDX_DATA_DIR)) begin
        dataDir_q <= wByte;
      end
      if (isIdx(idx_q, psp_pkg::IDX_DATA_LATCH)) begin
        outLatch_q <= wByte;  // [RULE_04]
      end
      if (isIdx(idx_q, psp_pkg::IDX_IRQ_ENABLES)) begin
        irqEnable_q <= wByte[psp_pkg::BIT_PORT_IRQ];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Inbound latch and flags. Hardware sets win over same-cycle clears.
  // ----------------------------------------------------------------------
  logic cpuReadsData;
  logic cpuWritesData;

  assign cpuReadsData  = rdSample && isIdx(idx_q, psp_pkg::IDX_DATA_LATCH);
  assign cpuWritesData = wrPhase && isIdx(idx_q, psp_pkg::IDX_DATA_LATCH);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      inLatch_q <= psp_pkg::RST_BYTE;
      inFull_q  <= 1'b0;
    end else if (!portSelect_q) begin
      inFull_q <= 1'b0;  // [RULE_09]
    end else if (writeDone && !inFull_q) begin
      inLatch_q <= wrHold_q;  // [RULE_14] [RULE_16]
      inFull_q  <= 1'b1;      // [RULE_06]
    end else if (cpuReadsData) begin
      inFull_q <= 1'b0;  // [RULE_06]
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      outFull_q <= 1'b0;
    end else if (!portSelect_q) begin
      outFull_q <= 1'b0;  // [RULE_09]
    end else if (cpuWritesData) begin
      outFull_q <= 1'b1;  // [RULE_07]
    end else if (readDone) begin
      outFull_q <= 1'b0;  // [RULE_07]
    end
  end

  // Overrun survives leaving port mode; software clears it by writing zero.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      overrun_q <= 1'b0;
    end else if (portSelect_q && writeDone && inFull_q) begin
      overrun_q <= 1'b1;  // [RULE_08]
    end else if (wrPhase && isIdx(idx_q, psp_pkg::IDX_STATUS_DIR)) begin
      overrun_q <= overrun_q & wByte[psp_pkg::BIT_OVERRUN];  // [RULE_09]
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      irqFlag_q <= 1'b0;
    end else if (readDone || writeDone) begin
      irqFlag_q <= 1'b1;  // [RULE_10]
    end else if (wrPhase && isIdx(idx_q, psp_pkg::IDX_IRQ_CLEAR)
                 && wByte[psp_pkg::BIT_PORT_IRQ]) begin
      irqFlag_q <= 1'b0;  // [RULE_10]
    end
  end

  assign irq = irqFlag_q && irqEnable_q;  // [RULE_11]

  // ----------------------------------------------------------------------
  // Pin drivers. Enables are active low.
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      dataPinOut <= 8'h00;
      dataPinOen <= psp_pkg::RST_DATA_DIR;
      ctrlPinOut <= 3'h0;
      ctrlPinOen <= psp_pkg::RST_CTRL_DIR;
    end else begin
      dataPinOut <= outLatch_q;  // [RULE_13]
      if (portSelect_q) begin
        dataPinOen <= extRead ? 8'h00 : 8'hff;  // [RULE_05] [RULE_16]
      end else begin
        dataPinOen <= dataDir_q;
      end
      ctrlPinOut <= ctrlLatch_q;
      ctrlPinOen <= ctrlDir_q;
    end
  end

endmodule

// >>> rtl/psp_pkg.sv
// Package for the parallel slave port: register indices, field positions,
// reset values and the AHB-Lite transfer codes.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package psp_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_DATA_LATCH  = 8'h08;
  localparam logic [7:0] IDX_CTRL_PINS   = 8'h09;
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_IRQ_CLEAR   = 8'h0d;
  localparam logic [7:0] IDX_DATA_DIR    = 8'h88;
  localparam logic [7:0] IDX_STATUS_DIR  = 8'h89;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int BIT_INBOUND_FULL  = 7;
  localparam int BIT_OUTBOUND_FULL = 6;
  localparam int BIT_OVERRUN       = 5;
  localparam int BIT_PORT_SELECT   = 4;
  localparam int BIT_PORT_IRQ      = 7;
  localparam int PIN_READ          = 0;
  localparam int PIN_WRITE         = 1;
  localparam int PIN_SELECT        = 2;

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [2:0] RST_CTRL_DIR = 3'h7;
  localparam logic [7:0] RST_DATA_DIR = 8'hff;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  // ----------------------------------------------------------------------
  // AHB-Lite codes.
  // ----------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage
